// ===== dmx_adc_model.sv
// Purpose: Converter model driving the ready clock and sample word
// Assumes: Half-rate ready clock, 200 ns period
// Notes: Clock stands still between bursts
`timescale 1ns/1ps
module dmx_adc_model
    import dmx_pkg::*;
(
    // Link outputs, no ready_reset_n is modelled
    output logic                ready_clk,
    output logic [SAMPLE_W-1:0] sample
);
    initial begin
        ready_clk = 1'b0;
        sample = '0;
    end
    // One new word on every ready edge
    task automatic send(input logic [SAMPLE_W-1:0] b, input int edges);
        #3;
        for (int n = 0; n < edges; n++) begin
            sample = b + SAMPLE_W'(n);
            ready_clk = ~ready_clk;
            #100;
        end
        // Released word must not look valid
        sample = ~sample;
    endtask : send
endmodule : dmx_adc_model

// ===== dmx_delay.sv
// Purpose: Selectable delay on the capture strobe derived from the ready clock
// Assumes: Tap index already clamped by the caller
// Notes:   Output delay is tap plus one aclk cycle
`timescale 1ns/1ps
module dmx_delay
    import dmx_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Strobe path
    input  wire logic       strobe_in,
    input  wire logic [1:0] tap,
    output logic            strobe_out
);
    logic [DELAY_TAPS-1:0] stage;

    for (genvar i = 0; i < DELAY_TAPS; i++) begin : g_stage
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stage[i] <= 1'b0;
            end else if (i == 0) begin
                stage[i] <= strobe_in;
            end else begin
                stage[i] <= stage[(i == 0) ? 0 : i-1];
            end
        end
    end

    assign strobe_out = stage[tap];
endmodule : dmx_delay

// ===== dmx_pkg.sv
// Purpose: Shared constants and carriers for the converter output demultiplexer
// Assumes: AXI4-Lite register access, 32-bit data, 40 MHz aclk
// Notes:   Each number lives here once; modules import the whole package
package dmx_pkg;
    // Sample and lane geometry
    localparam int SAMPLE_W     = 10;
    localparam int NARROW_W     = 8;
    localparam int LANES_MAX    = 8;
    localparam int LANES_NARROW = 4;
    localparam int IDX_W        = 3;
    localparam logic [IDX_W-1:0] LAST_IDX_WIDE   = 3'h7;
    localparam logic [IDX_W-1:0] LAST_IDX_NARROW = 3'h3;
    // Register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] COUNT_OFFSET  = 4'h8;
    // Control field positions and reset value
    localparam int CTRL_HALF_BIT  = 0;
    localparam int CTRL_RES_BIT   = 1;
    localparam int CTRL_RATIO_BIT = 2;
    localparam int CTRL_PHASE_BIT = 3;
    localparam int CTRL_DLY_LSB   = 8;
    localparam int DLY_W          = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // Status field positions
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_STATE_LSB = 1;
    localparam int STAT_IDX_LSB   = 4;
    // Clock path delay
    localparam int DELAY_RANGE_PS = 250;
    localparam int CLK_PERIOD_PS  = 25000;
    localparam int DELAY_TAPS     = 4;
    localparam logic signed [DLY_W-1:0] DELAY_CENTER = 3'sh2;
    localparam logic signed [DLY_W-1:0] DELAY_MIN    = -3'sh2;
    localparam logic signed [DLY_W-1:0] DELAY_MAX    = 3'sh1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RESET = 3'b010,
        ST_RUN   = 3'b100
    } dmx_state_e;

    typedef struct packed {
        logic signed [DLY_W-1:0] input_delay_control;
        logic                    cascade_second;
        logic                    ratio_select;
        logic                    resolution_select;
        logic                    half_rate;
    } dmx_ctrl_s;

    typedef struct packed {
        logic                ready_clk;
        logic                reset_n;
        logic                sync_reset;
        logic [SAMPLE_W-1:0] data;
    } dmx_pins_s;

    // Idle pin levels; reset_n idles high so aresetn alone never reads as an external reset pulse
    localparam dmx_pins_s PINS_IDLE = '{ready_clk: 1'b0, reset_n: 1'b1, sync_reset: 1'b0, data: '0};
endpackage : dmx_pkg

// ===== dmx_sync.sv
// Purpose: Two-stage synchroniser for pins sampled on aclk
// Assumes: Bits are independent levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module dmx_sync
    import dmx_pkg::*;
(
    // Clock and reset
    input  wire logic      aclk,
    input  wire logic      aresetn,
    // Pins in, synchronised out
    input  wire dmx_pins_s pin,
    output dmx_pins_s      pin_sync
);
    dmx_pins_s stage1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1   <= PINS_IDLE;
            pin_sync <= PINS_IDLE;
        end else begin
            stage1   <= pin;
            pin_sync <= stage1;
        end
    end
endmodule : dmx_sync

// ===== dmx_top.sv
// Purpose: Demultiplexer spreading converter samples over parallel output lanes
// Assumes: Ready clock and pins come from another domain and are synchronised here
// Notes:   One clock-path delay step equals one aclk period at this rate
`timescale 1ns/1ps
module dmx_top
    import dmx_pkg::*;
(
    // Clock and reset
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]                    s_axi_awaddr,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                          s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                                s_axi_bresp,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]                    s_axi_araddr,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    output logic [31:0]                               s_axi_rdata,
    output logic [1:0]                                s_axi_rresp,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready,
    // Converter side pins
    input  wire logic                                 ready_clk_pin,
    input  wire logic [SAMPLE_W-1:0]                  sample_pin,
    input  wire logic                                 dmx_reset_n_pin,
    input  wire logic                                 sync_reset_pin,
    // Output lanes
    output logic [LANES_MAX-1:0][SAMPLE_W-1:0]        lane_data,
    output logic                                      lane_ready
);
    dmx_ctrl_s                          ctrl;
    dmx_state_e                         state;
    dmx_pins_s                          pins_raw;
    dmx_pins_s                          pins;
    logic                               ready_prev;
    logic                               sync_prev;
    logic                               rise;
    logic                               fall;
    logic                               cap_strobe;
    logic                               dstrobe;
    logic [1:0]                         tap;
    logic signed [DLY_W-1:0]            dly_clamped;
    logic [IDX_W-1:0]                   idx;
    logic [IDX_W-1:0]                   last_idx;
    logic [SAMPLE_W-1:0]                word;
    logic [LANES_MAX-1:0][SAMPLE_W-1:0] lane_buf;
    logic [31:0]                        frame_count;
    logic                               aw_got;
    logic                               w_got;
    logic [ADDR_W-1:0]                  aw_addr;
    logic [31:0]                        w_data;
    logic [3:0]                         w_strb;
    logic                               do_write;
    logic                               ctrl_write;

    // Pin synchronisation
    assign pins_raw = '{ready_clk: ready_clk_pin, reset_n: dmx_reset_n_pin,
                        sync_reset: sync_reset_pin, data: sample_pin};

    dmx_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      (pins_raw),
        .pin_sync (pins)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_prev <= 1'b0;
            sync_prev  <= 1'b0;
        end else begin
            ready_prev <= pins.ready_clk;
            sync_prev  <= pins.sync_reset;
        end
    end

    assign rise = pins.ready_clk & ~ready_prev;
    assign fall = ~pins.ready_clk & ready_prev;

    // Half rate uses both edges, full rate one edge chosen by cascade phase
    always_comb begin
        if (ctrl.half_rate) begin
            cap_strobe = rise | fall;
        end else begin
            cap_strobe = ctrl.cascade_second ? fall : rise;
        end
    end

    // Clock path delay, clamped so a bad code cannot leave the tap range
    always_comb begin
        if (ctrl.input_delay_control < DELAY_MIN) begin
            dly_clamped = DELAY_MIN;
        end else if (ctrl.input_delay_control > DELAY_MAX) begin
            dly_clamped = DELAY_MAX;
        end else begin
            dly_clamped = ctrl.input_delay_control;
        end
    end

    assign tap = 2'(dly_clamped + DELAY_CENTER);

    dmx_delay u_delay (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .strobe_in  (cap_strobe),
        .tap        (tap),
        .strobe_out (dstrobe)
    );

    // Acquisition state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
        end else if (!pins.reset_n) begin
            state <= ST_RESET;
        end else begin
            unique case (state)
                ST_IDLE:  state <= ST_IDLE;
                ST_RESET: state <= ST_RUN;
                ST_RUN:   state <= ST_RUN;
            endcase
        end
    end

    // Lane filling
    assign last_idx = ctrl.ratio_select ? LAST_IDX_WIDE : LAST_IDX_NARROW;
    assign word     = ctrl.resolution_select ? pins.data
                                             : {2'h0, pins.data[NARROW_W-1:0]};

    // A config write or sync reset drops the partial frame so lanes never mix modes
    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_RUN || ctrl_write) begin
            idx <= '0;
        end else if (pins.sync_reset && !sync_prev) begin
            idx <= '0;
        end else if (dstrobe) begin
            idx <= (idx == last_idx) ? '0 : idx + 3'h1;
        end
    end

    for (genvar i = 0; i < LANES_MAX; i++) begin : g_lane
        always_ff @(posedge aclk) begin
            if (!aresetn || !pins.reset_n) begin
                lane_buf[i]  <= '0;
                lane_data[i] <= '0;
            end else if (state == ST_RUN && dstrobe) begin
                if (idx == IDX_W'(i)) begin
                    lane_buf[i] <= word;
                end
                if (idx == last_idx) begin
                    if (IDX_W'(i) > last_idx) begin
                        lane_data[i] <= '0;
                    end else if (idx == IDX_W'(i)) begin
                        lane_data[i] <= word;
                    end else begin
                        lane_data[i] <= lane_buf[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !pins.reset_n) begin
            lane_ready  <= 1'b0;
            frame_count <= '0;
        end else begin
            lane_ready <= (state == ST_RUN) && dstrobe && (idx == last_idx) && !ctrl_write
                          && !(pins.sync_reset && !sync_prev);
            if (lane_ready) begin
                frame_count <= frame_count + 32'h0000_0001;
            end
        end
    end

    // AXI4-Lite write side, address and data taken in either order
    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign do_write      = aw_got && w_got && !s_axi_bvalid;
    assign ctrl_write    = do_write && (aw_addr == CTRL_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == CTRL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register, only byte lanes 0 and 1 hold fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= dmx_ctrl_s'(CTRL_RESET[$bits(dmx_ctrl_s)-1:0]);
        end else if (ctrl_write) begin
            if (w_strb[0]) begin
                ctrl.half_rate         <= w_data[CTRL_HALF_BIT];
                ctrl.resolution_select <= w_data[CTRL_RES_BIT];
                ctrl.ratio_select      <= w_data[CTRL_RATIO_BIT];
                ctrl.cascade_second    <= w_data[CTRL_PHASE_BIT];
            end
            if (w_strb[1]) begin
                ctrl.input_delay_control <= w_data[CTRL_DLY_LSB +: DLY_W];
            end
        end
    end

    // AXI4-Lite read side
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= '0;
            unique case (s_axi_araddr)
                CTRL_OFFSET: begin
                    s_axi_rdata[CTRL_HALF_BIT]              <= ctrl.half_rate;
                    s_axi_rdata[CTRL_RES_BIT]               <= ctrl.resolution_select;
                    s_axi_rdata[CTRL_RATIO_BIT]             <= ctrl.ratio_select;
                    s_axi_rdata[CTRL_PHASE_BIT]             <= ctrl.cascade_second;
                    s_axi_rdata[CTRL_DLY_LSB +: DLY_W]      <= ctrl.input_delay_control;
                end
                STATUS_OFFSET: begin
                    s_axi_rdata[STAT_RUN_BIT]               <= (state == ST_RUN);
                    s_axi_rdata[STAT_STATE_LSB +: 3]        <= state;
                    s_axi_rdata[STAT_IDX_LSB +: IDX_W]      <= idx;
                end
                COUNT_OFFSET: s_axi_rdata <= frame_count;
                default:      s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    property p_half_rate_edges;
        @(posedge aclk) disable iff (!aresetn)
        ctrl.half_rate && fall |-> cap_strobe;
    endproperty
    a_half_rate_edges: assert property (p_half_rate_edges)
        else $error("Half-rate mode missed a falling ready edge");

    property p_narrow_width;
        @(posedge aclk) disable iff (!aresetn)
        $rose(lane_ready) && !ctrl.resolution_select && !$past(ctrl_write)
            |-> lane_data[0][SAMPLE_W-1:NARROW_W] == 2'h0;
    endproperty
    a_narrow_width: assert property (p_narrow_width)
        else $error("8-bit mode left upper bits set");

    property p_ratio_frame;
        @(posedge aclk) disable iff (!aresetn)
        lane_ready && !$past(ctrl_write) |-> $past(idx) == $past(last_idx);
    endproperty
    a_ratio_frame: assert property (p_ratio_frame)
        else $error("Frame closed at the wrong lane count");

    property p_idle_silent;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_IDLE |=> !lane_ready;
    endproperty
    a_idle_silent: assert property (p_idle_silent)
        else $error("Output produced before any reset was seen");

    property p_release_runs;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_RESET && pins.reset_n |=> state == ST_RUN ##0 idx == '0;
    endproperty
    a_release_runs: assert property (p_release_runs)
        else $error("Release did not start at lane 0");

    property p_delay_tap;
        @(posedge aclk) disable iff (!aresetn)
        cap_strobe && tap == 2'h1 && !ctrl_write ##1 !ctrl_write |-> ##1 dstrobe;
    endproperty
    a_delay_tap: assert property (p_delay_tap)
        else $error("Capture strobe not delayed by tap plus one");

    property p_second_phase;
        @(posedge aclk) disable iff (!aresetn)
        !ctrl.half_rate && ctrl.cascade_second && rise |-> !cap_strobe;
    endproperty
    a_second_phase: assert property (p_second_phase)
        else $error("Second-phase block captured on the rising edge");

    property p_reset_holds;
        @(posedge aclk) disable iff (!aresetn)
        !pins.reset_n |=> !lane_ready && lane_data == '0;
    endproperty
    a_reset_holds: assert property (p_reset_holds)
        else $error("Lanes active during external reset");
endmodule : dmx_top

// ===== tb_top.sv
// Purpose: Self-checking bench for dmx_top
// Assumes: Model bursts are even in edges, so the clock idles low
// Notes: Taps 0 and 1 keep the strobe clear of data edges
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; $display("wrong value %s %h %h", nm, e, g); end end
module tb_top
    import dmx_pkg::*;
;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, rclk, lane_ready;
    logic dmx_rst_n = 1, sync_rst = 0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp;
    logic [SAMPLE_W-1:0] smp;
    logic [LANES_MAX-1:0][SAMPLE_W-1:0] lanes;
    int failures = 0, checked = 0;
    dmx_top dmx_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ready_clk_pin(rclk),
        .sample_pin(smp), .dmx_reset_n_pin(dmx_rst_n), .sync_reset_pin(sync_rst), .lane_data(lanes),
        .lane_ready(lane_ready));
    dmx_adc_model dmx_adc_model_i (.ready_clk(rclk), .sample(smp));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    task automatic tally_and_finish;
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // Ready is looked at on the falling edge, which equals its value at the next rising edge
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        logic [2:0] t;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            t = {awvalid & awready, wvalid & wready, bvalid & bready};
            r = bresp;
            @(posedge aclk);
            if (t[2]) awvalid <= 1'b0;
            if (t[1]) wvalid <= 1'b0;
            if (t[0]) begin
                bready <= 1'b0;
                // Let an edge pass so a following call never re-raises bready in this time step
                @(posedge aclk);
                return;
            end
        end
        failures++;
        tally_and_finish();
    endtask : axi_wr
    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        logic [1:0] t;
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            t = {arvalid & arready, rvalid & rready};
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (t[1]) arvalid <= 1'b0;
            if (t[0]) begin
                rready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        failures++;
        tally_and_finish();
    endtask : axi_rd
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        `CHK("rdata", e, d)
        `CHK("rresp", er, r)
    endtask : rd_chk
    task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_wr(a, d, r);
        `CHK("bresp", er, r)
    endtask : wr_chk
    // Burst from the model while watching for one lane_ready pulse
    task automatic frame(input logic [SAMPLE_W-1:0] b, input int edges, output logic got,
                         output logic [LANES_MAX-1:0][SAMPLE_W-1:0] seen);
        got = 1'b0;
        seen = '0;
        fork
            dmx_adc_model_i.send(b, edges);
            for (int n = 0; n < edges * 8 + 40 && !got; n++) begin
                @(negedge aclk);
                if (lane_ready === 1'b1) begin
                    got = 1'b1;
                    seen = lanes;
                end
            end
        join
        @(posedge aclk);
    endtask : frame
    function automatic logic [LANES_MAX-1:0][SAMPLE_W-1:0] exp_lanes(input logic [SAMPLE_W-1:0] b,
                                                                    input int cnt, input int st,
                                                                    input logic [SAMPLE_W-1:0] m);
        exp_lanes = '0;
        for (int k = 0; k < cnt; k++) exp_lanes[k] = (b + SAMPLE_W'(k * st)) & m;
    endfunction : exp_lanes
    task automatic s_idle;
        logic got;
        logic [LANES_MAX-1:0][SAMPLE_W-1:0] seen;
        @(negedge aclk);
        `CHK("lanes", '0, lanes)
        @(posedge aclk);
        rd_chk(CTRL_OFFSET, CTRL_RESET, RESP_OKAY);
        rd_chk(STATUS_OFFSET, 32'h0000_0002, RESP_OKAY);
        rd_chk(4'hc, 32'h0000_0000, RESP_SLVERR);
        wr_chk(STATUS_OFFSET, 32'h0000_ffff, RESP_SLVERR);
        frame(10'h155, 8, got, seen);
        `CHK("idle frame", 1'b0, got)
    endtask : s_idle
    task automatic s_start;
        dmx_rst_n <= 1'b0;
        repeat (4) @(posedge aclk);
        rd_chk(STATUS_OFFSET, 32'h0000_0004, RESP_OKAY);
        dmx_rst_n <= 1'b1;
        repeat (5) @(posedge aclk);
        rd_chk(STATUS_OFFSET, 32'h0000_0009, RESP_OKAY);
    endtask : s_start
    // Config bits: cascade_second, ratio, resolution, half rate
    task automatic s_modes;
        logic got;
        logic [LANES_MAX-1:0][SAMPLE_W-1:0] seen;
        logic [3:0] cfg [4] = '{4'h3, 4'h5, 4'h2, 4'ha};
        int n, st;
        logic [31:0] wd;
        for (int i = 0; i < 4; i++) begin
            n = cfg[i][2] ? 8 : 4;
            st = cfg[i][0] ? 1 : 2;
            // Delay codes -2 and -1 give taps 0 and 1, both inside the stable data window
            wd = {21'h00_0000, i[0] ? 3'h7 : 3'h6, 4'h0, cfg[i]};
            wr_chk(CTRL_OFFSET, wd, RESP_OKAY);
            rd_chk(CTRL_OFFSET, wd, RESP_OKAY);
            frame(10'h1fc, n * st, got, seen);
            `CHK("lanes", exp_lanes(10'h1fc + cfg[i][3], n, st, cfg[i][1] ? 10'h3ff : 10'h0ff), seen)
            rd_chk(COUNT_OFFSET, 32'(i + 1), RESP_OKAY);
        end
    endtask : s_modes
    task automatic s_sync;
        logic got;
        logic [LANES_MAX-1:0][SAMPLE_W-1:0] seen;
        frame(10'h020, 2, got, seen);
        `CHK("partial", 1'b0, got)
        sync_rst <= 1'b1;
        repeat (4) @(posedge aclk);
        sync_rst <= 1'b0;
        repeat (4) @(posedge aclk);
        frame(10'h040, 8, got, seen);
        `CHK("realigned", exp_lanes(10'h041, 4, 2, 10'h3ff), seen)
    endtask : s_sync
    task automatic s_abort;
        logic got;
        logic [LANES_MAX-1:0][SAMPLE_W-1:0] seen;
        dmx_rst_n <= 1'b0;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        `CHK("lanes in reset", '0, lanes)
        `CHK("ready in reset", 1'b0, lane_ready)
        @(posedge aclk);
        dmx_rst_n <= 1'b1;
        repeat (5) @(posedge aclk);
        frame(10'h300, 8, got, seen);
        `CHK("restart", exp_lanes(10'h301, 4, 2, 10'h3ff), seen)
    endtask : s_abort
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_idle();
        s_start();
        s_modes();
        s_sync();
        s_abort();
        tally_and_finish();
    end
endmodule : tb_top
